// [rtl/ocm_defs.vh]
// constants for the on-chip memory decode and nonvolatile array control
// assumes a 16-bit core address, 8-bit data and register indices as printed
`ifndef OCM_DEFS_VH
`define OCM_DEFS_VH

// register indices; the APB byte address is four times the index
`define OCM_IDX_PROG      14'h103B
`define OCM_IDX_REMAP     14'h103D
`define OCM_IDX_SETUP     14'h103F
`define OCM_IDX_PAGE      8'h40

// reset values and masks
`define OCM_PROG_RST      8'h00
`define OCM_PROG_MASK     8'hDF
`define OCM_REMAP_RST     8'h01
`define OCM_SETUP_RST     8'h00
`define OCM_SETUP_MASK    8'h03
`define OCM_FLOAT         8'hFF
`define OCM_ERASED        8'hFF

// program control fields
`define OCM_B_PUMP        0
`define OCM_B_LATCH       1
`define OCM_B_ERASE       2
`define OCM_B_ROW         3
`define OCM_B_BYTE        4

// setup register fields
`define OCM_B_ARRAY_EN    0
`define OCM_B_ROM_EN      1

// operating modes
`define OCM_MODE_BOOT     2'b00
`define OCM_MODE_SINGLE   2'b01
`define OCM_MODE_TEST     2'b10
`define OCM_MODE_EXP      2'b11

// regions
`define OCM_ROM_BASE      16'hD000
`define OCM_BOOT_BASE     16'hBF40
`define OCM_BOOT_TOP      16'hBFFF
`define OCM_VEC_BASE      16'hBFC0
`define OCM_NVM_PAGE      7'h5B
`define OCM_NVM_DEPTH     512

// remap write window in bus clock cycles
`define OCM_REMAP_WINDOW  7'd64

`endif

// [rtl/ocm_memory_ctrl.v]
// on-chip memory decode, remap register and nonvolatile array control
// assumes the core bus is synchronous to i_clk and software uses APB
//
// What this block does
// - an enabled internal resource wins over an external device mapped there
// - internal reads ignore the external data inputs
// - internal writes also drive data pins; externals must stay off them
// - direction, strobe, address and write data go out on every access
// - bootstrap mode enables the 192-byte boot region with vectors inside
// - test mode uses expanded map, vectors fetched externally at the high range
// - control block may sit at the base of any 4K page
// - remap register takes one write in the first 64 cycles, then read-only
// - remap resets to 0x01: RAM at zero, control block at 0x1000
// - remap nibbles compare against address bits 15..12 for RAM and block
// - control block beats RAM and ROM; RAM beats mask ROM
// - unused control block locations read the undriven bus value
// - 12K mask ROM at top of map, off when its enable cell is zero
// - single-chip mode keeps mask ROM on regardless of the cell
// - boot ROM only enabled after a reset taken in bootstrap mode
// - 512-byte array at page B6, off when its enable cell is zero
// - erased byte reads 0xFF; programming only clears bits (AND)
// - reset clears program control; bit 5 always reads zero
// - byte erase beats row/bulk; erase mode, latch and pump bits decoded
// - a write setting latch and pump together while both are clear sets neither
// - array writes are ignored while the pump is on
// - array is cut off the read bus while an operation runs
// - with latch clear the array reads like ordinary ROM
`timescale 1ns/10ps
`default_nettype none
`include "ocm_defs.vh"

module ocm_memory_ctrl (
    input  wire        i_clk,
    input  wire        i_rst,
    // APB register port
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [15:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr,
    // core bus
    input  wire        i_cpu_req,
    input  wire        i_cpu_we,
    input  wire        i_cpu_vec,
    input  wire [15:0] i_cpu_addr,
    input  wire [7:0]  i_cpu_wdata,
    output reg  [7:0]  o_cpu_rdata,
    output reg         o_cpu_ack,
    // external multiplexed bus
    output reg         o_ext_rw,
    output reg         o_address_latch_strobe,
    output reg  [15:0] o_ext_addr,
    output reg  [7:0]  o_ext_wdata,
    output reg         o_ext_data_oe,
    input  wire [7:0]  i_ext_rdata,
    // internal RAM and ROM macros, combinational read
    output wire        o_ram_we,
    output wire [8:0]  o_ram_addr,
    output wire [7:0]  o_ram_wdata,
    input  wire [7:0]  i_ram_rdata,
    output wire [13:0] o_rom_addr,
    input  wire [7:0]  i_rom_rdata,
    output wire [7:0]  o_boot_addr,
    input  wire [7:0]  i_boot_rdata,
    // straps caught after reset release
    input  wire [1:0]  i_mode,
    input  wire [1:0]  i_cfg_cells,
    // status
    output wire        o_pump_voltage_enable
);

    // ****************************************
    // state
    // ****************************************
    localparam [2:0] SEL_EXT  = 3'd0;
    localparam [2:0] SEL_REG  = 3'd1;
    localparam [2:0] SEL_RAM  = 3'd2;
    localparam [2:0] SEL_ROM  = 3'd3;
    localparam [2:0] SEL_BOOT = 3'd4;
    localparam [2:0] SEL_NVM  = 3'd5;
    localparam [2:0] SEL_NONE = 3'd6;

    reg [7:0]  nvm_program_control_r;
    reg [7:0]  memory_remap_register_r;
    reg [7:0]  nvm_setup_register_r;
    reg [1:0]  mode_r;
    reg        boot_en_r;
    reg        caught_r;
    reg [6:0]  win_cnt_r;
    reg        remap_done_r;
    reg [8:0]  lat_addr_r;
    reg [7:0]  lat_data_r;
    reg [7:0]  nvm_mem [0:`OCM_NVM_DEPTH-1];

    reg [15:0] a;
    reg [2:0]  sel;
    reg [7:0]  rd_data;
    reg [7:0]  prog_nxt;
    integer    i;

    wire latch_on = nvm_program_control_r[`OCM_B_LATCH];
    wire pump_on  = nvm_program_control_r[`OCM_B_PUMP];
    // an operation runs only with latch and pump both on; a lone pump bit leaves reads alone
    wire nvm_busy = latch_on && pump_on;
    assign o_pump_voltage_enable = pump_on;

    // ****************************************
    // functions
    // ****************************************
    // unused slots in the block read as the floating bus
    // full register index; core reads rebuild it from the block offset
    function [7:0] reg_rd;
        input [13:0] idx;
        begin
            case (idx)
                `OCM_IDX_PROG:  reg_rd = nvm_program_control_r & `OCM_PROG_MASK;
                `OCM_IDX_REMAP: reg_rd = memory_remap_register_r;
                `OCM_IDX_SETUP: reg_rd = nvm_setup_register_r;
                default:        reg_rd = `OCM_FLOAT;
            endcase
        end
    endfunction

    // index from an APB byte address, or all ones when unaligned
    function [13:0] apb_idx;
        input [15:0] pa;
        begin
            if (pa[1:0] != 2'b00) begin
                apb_idx = 14'h3FFF;
            end else begin
                apb_idx = pa[15:2];
            end
        end
    endfunction

    // 4K page match of an address against one remap nibble
    function page_hit;
        input [15:0] adr;
        input [3:0]  nib;
        begin
            page_hit = (adr[15:12] == nib);
        end
    endfunction

    // ****************************************
    // address decode
    // ****************************************
    wire special = (mode_r == `OCM_MODE_BOOT) || (mode_r == `OCM_MODE_TEST);
    wire expanded = (mode_r == `OCM_MODE_EXP) || (mode_r == `OCM_MODE_TEST);
    wire rom_en = nvm_setup_register_r[`OCM_B_ROM_EN] ||
                  (mode_r == `OCM_MODE_SINGLE);
    wire nvm_en = nvm_setup_register_r[`OCM_B_ARRAY_EN];
    // vector fetches are only redirected in the two special modes
    wire vec_hit = special && i_cpu_vec && (i_cpu_addr[15:6] == 10'h3FF);

    always @* begin
        a = i_cpu_addr;
        // vectors move into the high boot range in the special modes
        if (vec_hit) begin
            a = `OCM_VEC_BASE | {10'h000, i_cpu_addr[5:0]};
        end
    end

    // region hits on the redirected address; priority is applied below
    wire in_block = page_hit(a, memory_remap_register_r[3:0]) && (a[11:6] == 6'h00);
    wire in_ram   = page_hit(a, memory_remap_register_r[7:4]) && (a[11:9] == 3'b000);
    wire in_rom   = rom_en && (a >= `OCM_ROM_BASE);
    wire in_boot  = boot_en_r && (a >= `OCM_BOOT_BASE) && (a <= `OCM_BOOT_TOP);
    wire in_nvm   = nvm_en && (a[15:9] == `OCM_NVM_PAGE);

    // priority: block, RAM, ROMs, array, then external
    always @* begin
        if (in_block) begin
            sel = SEL_REG;
        end else if (in_ram) begin
            sel = SEL_RAM;
        end else if (in_rom) begin
            sel = SEL_ROM;
        end else if (in_boot) begin
            sel = SEL_BOOT;
        end else if (in_nvm) begin
            sel = SEL_NVM;
        end else if (expanded) begin
            sel = SEL_EXT;
        end else begin
            sel = SEL_NONE;
        end
    end

    assign o_ram_addr  = a[8:0];
    assign o_ram_wdata = i_cpu_wdata;
    assign o_ram_we    = i_cpu_req && i_cpu_we && (sel == SEL_RAM);
    assign o_rom_addr  = a[13:0] - 14'h1000;
    assign o_boot_addr = a[7:0] - 8'h40;

    // read data; external inputs only used when nothing inside claims the address
    always @* begin
        case (sel)
            SEL_EXT:  rd_data = i_ext_rdata;
            SEL_REG:  rd_data = reg_rd({`OCM_IDX_PAGE, a[5:0]});
            SEL_RAM:  rd_data = i_ram_rdata;
            SEL_ROM:  rd_data = i_rom_rdata;
            SEL_BOOT: rd_data = i_boot_rdata;
            SEL_NVM:  rd_data = nvm_busy ? `OCM_FLOAT : nvm_mem[a[8:0]];
            default:  rd_data = `OCM_FLOAT;
        endcase
    end

    // ****************************************
    // core and external bus timing
    // ****************************************
    // every access is echoed on the external bus, internal or not
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cpu_rdata            <= 8'h00;
            o_cpu_ack              <= 1'b0;
            o_ext_rw               <= 1'b1;
            o_address_latch_strobe <= 1'b0;
            o_ext_addr             <= 16'h0000;
            o_ext_wdata            <= 8'h00;
            o_ext_data_oe          <= 1'b0;
        end else begin
            o_cpu_ack              <= i_cpu_req;
            o_address_latch_strobe <= i_cpu_req;
            o_ext_data_oe          <= i_cpu_req && i_cpu_we;
            if (i_cpu_req) begin
                o_ext_rw    <= ~i_cpu_we;
                o_ext_addr  <= a;
                o_ext_wdata <= i_cpu_wdata;
                if (!i_cpu_we) begin
                    o_cpu_rdata <= rd_data;
                end
            end
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    wire [13:0] pidx   = apb_idx(i_paddr);
    wire        pmap   = (pidx == `OCM_IDX_PROG) || (pidx == `OCM_IDX_REMAP) ||
                         (pidx == `OCM_IDX_SETUP);
    wire        pacc   = i_psel && i_penable;
    wire        pwr    = pacc && i_pwrite && pmap;

    assign o_pready  = 1'b1;
    assign o_pslverr = pacc && !pmap;

    // ****************************************
    // register write strobes
    // ****************************************
    wire prog_wr  = pwr && (pidx == `OCM_IDX_PROG);
    wire remap_wr = pwr && (pidx == `OCM_IDX_REMAP);
    // configuration cells only take software writes from the special modes
    wire setup_wr = pwr && (pidx == `OCM_IDX_SETUP) && special;

    // read data is captured in the setup phase so it comes from a flop
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable) begin
            o_prdata <= pmap ? {24'h000000, reg_rd(pidx)} : 32'h0000_0000;
        end
    end

    // ****************************************
    // strap capture and remap window
    // ****************************************
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            caught_r             <= 1'b0;
            mode_r               <= `OCM_MODE_EXP;
            boot_en_r            <= 1'b0;
            nvm_setup_register_r <= `OCM_SETUP_RST;
        end else begin
            if (!caught_r) begin
                caught_r             <= 1'b1;
                mode_r               <= i_mode;
                boot_en_r            <= (i_mode == `OCM_MODE_BOOT);
                nvm_setup_register_r <= {6'h00, i_cfg_cells};
            end else if (setup_wr) begin
                nvm_setup_register_r <= i_pwdata[7:0] & `OCM_SETUP_MASK;
            end
        end
    end

    // the counter parks at the window length, so the window never reopens
    wire remap_open = (win_cnt_r < `OCM_REMAP_WINDOW);

    // one write, only while the window is still open
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            win_cnt_r               <= 7'd0;
            remap_done_r            <= 1'b0;
            memory_remap_register_r <= `OCM_REMAP_RST;
        end else begin
            if (remap_open) begin
                win_cnt_r <= win_cnt_r + 7'd1;
            end
            if (remap_wr && !remap_done_r && remap_open) begin
                memory_remap_register_r <= i_pwdata[7:0];
                remap_done_r            <= 1'b1;
            end
        end
    end

    // ****************************************
    // program control register
    // ****************************************
    always @* begin
        prog_nxt = i_pwdata[7:0] & `OCM_PROG_MASK;
        // runaway guard: latch and pump may not rise in one write
        if (prog_nxt[`OCM_B_LATCH] && prog_nxt[`OCM_B_PUMP] && !latch_on && !pump_on) begin
            prog_nxt[`OCM_B_LATCH] = 1'b0;
            prog_nxt[`OCM_B_PUMP]  = 1'b0;
        end
    end

    // the operation lands when software turns the pump off; its length is software timed
    wire pump_off = prog_wr && pump_on && latch_on && !prog_nxt[`OCM_B_PUMP];

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            nvm_program_control_r <= `OCM_PROG_RST;
        end else if (prog_wr) begin
            nvm_program_control_r <= prog_nxt;
        end
    end

    // ****************************************
    // nonvolatile array
    // ****************************************
    wire arr_wr = i_cpu_req && i_cpu_we && (sel == SEL_NVM);

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lat_addr_r <= 9'h000;
            lat_data_r <= `OCM_ERASED;
        end else if (arr_wr && latch_on && !pump_on) begin
            lat_addr_r <= a[8:0];
            lat_data_r <= i_cpu_wdata;
        end
    end

    // array contents are not reset; they are nonvolatile
    always @(posedge i_clk) begin
        if (pump_off) begin
            if (nvm_program_control_r[`OCM_B_ERASE]) begin
                for (i = 0; i < `OCM_NVM_DEPTH; i = i + 1) begin
                    if (nvm_program_control_r[`OCM_B_BYTE]) begin
                        if (i[8:0] == lat_addr_r) begin
                            nvm_mem[i] <= `OCM_ERASED;
                        end
                    end else if (nvm_program_control_r[`OCM_B_ROW]) begin
                        if (i[8:4] == lat_addr_r[8:4]) begin
                            nvm_mem[i] <= `OCM_ERASED;
                        end
                    end else begin
                        nvm_mem[i] <= `OCM_ERASED;
                    end
                end
            end else begin
                // programming can only clear bits
                nvm_mem[lat_addr_r] <= nvm_mem[lat_addr_r] & lat_data_r;
            end
        end
    end
    // a write arriving with the pump on is never latched, so a running operation keeps its target

endmodule
`default_nettype wire

// [tb/ocm_far_model.sv]
// far side model: RAM and ROM macros plus an external device
// assumes combinational macro reads and one write port on the RAM
`timescale 1ns/10ps
`default_nettype none
module ocm_far_model (
    input  wire logic        i_clk,
    input  wire logic        i_ram_we,
    input  wire logic [8:0]  i_ram_addr,
    input  wire logic [7:0]  i_ram_wdata,
    input  wire logic [13:0] i_rom_addr,
    input  wire logic [7:0]  i_boot_addr,
    input  wire logic        i_ext_data_oe,
    output logic      [7:0]  o_ram_rdata,
    output logic      [7:0]  o_rom_rdata,
    output logic      [7:0]  o_boot_rdata,
    output logic      [7:0]  o_ext_rdata
);
    logic [7:0] mem_r [512];
    always @(posedge i_clk) begin
        if (i_ram_we) begin
            mem_r[i_ram_addr] <= i_ram_wdata;
        end
    end
    assign o_ram_rdata  = mem_r[i_ram_addr];
    assign o_rom_rdata  = i_rom_addr[7:0] ^ 8'hA5;
    assign o_boot_rdata = i_boot_addr ^ 8'h3C;
    // off the pins while the device writes, so the inputs float to the inverse
    assign o_ext_rdata  = i_ext_data_oe ? 8'h3C : 8'hC3;
endmodule
`default_nettype wire

// [tb/ocm_memory_ctrl_props.sv]
// checker for the memory decode block, bound to its top module
// assumes one clock domain with an asynchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module ocm_memory_ctrl_props (
    input wire        i_clk,
    input wire        i_rst,
    input wire        i_psel,
    input wire        i_penable,
    input wire        i_pwrite,
    input wire [15:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire        o_pslverr,
    input wire        i_cpu_req,
    input wire        i_cpu_we,
    input wire        i_cpu_vec,
    input wire [15:0] i_cpu_addr,
    input wire [7:0]  i_cpu_wdata,
    input wire        o_cpu_ack,
    input wire        o_ext_rw,
    input wire        o_address_latch_strobe,
    input wire [15:0] o_ext_addr,
    input wire [7:0]  o_ext_wdata,
    input wire        o_ext_data_oe,
    input wire        o_ram_we,
    input wire [8:0]  o_ram_addr,
    input wire [13:0] o_rom_addr,
    input wire        o_pump_voltage_enable
);
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_ack_after_req: assert property (o_cpu_ack == $past(i_cpu_req))
        else $error("ack does not follow request");
    chk_strobe_every: assert property (i_cpu_req |=> o_address_latch_strobe)
        else $error("strobe missing");
    chk_ext_addr_out: assert property (i_cpu_req && !i_cpu_vec |=> o_ext_addr == $past(i_cpu_addr))
        else $error("external address wrong");
    chk_write_pins: assert property (i_cpu_req && i_cpu_we |=> o_ext_data_oe && !o_ext_rw
        && o_ext_wdata == $past(i_cpu_wdata))
        else $error("write data not on pins");
    chk_read_no_drive: assert property (i_cpu_req && !i_cpu_we |=> o_ext_rw && !o_ext_data_oe)
        else $error("pins driven on read");
    chk_ram_we_cause: assert property (o_ram_we |-> i_cpu_req && i_cpu_we
        && o_ram_addr == i_cpu_addr[8:0])
        else $error("stray RAM write");
    chk_rom_offset: assert property (i_cpu_req && i_cpu_addr[15:12] >= 4'hD
        |-> o_rom_addr == i_cpu_addr[13:0] - 14'h1000)
        else $error("ROM offset wrong");
    chk_pump_source: assert property ($rose(o_pump_voltage_enable) |-> $past(i_psel && i_penable
        && i_pwrite && i_paddr == 16'h40EC && i_pwdata[0]))
        else $error("pump rose without write");
    chk_unmapped_err: assert property (i_psel && i_penable && i_paddr == 16'h0000 |-> o_pslverr)
        else $error("unmapped access not refused");
endmodule
bind ocm_memory_ctrl ocm_memory_ctrl_props ocm_memory_ctrl_props_i (.*);
`default_nettype wire

// [tb/ocm_memory_ctrl_test.sv]
// self-checking bench for the memory decode and array control block
// assumes the far side model and the bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module ocm_memory_ctrl_test;
    localparam logic [15:0] a_prog  = 16'h40EC;
    localparam logic [15:0] a_remap = 16'h40F4;
    logic        i_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic        i_cpu_req = 0, i_cpu_we = 0, i_cpu_vec = 0, err;
    logic [15:0] i_paddr = 0, i_cpu_addr = 0;
    logic [31:0] i_pwdata = 0;
    logic [7:0]  i_cpu_wdata = 0, q;
    logic [1:0]  i_mode = 0, i_cfg_cells = 0;
    wire  [31:0] o_prdata;
    wire  [15:0] o_ext_addr;
    wire  [13:0] o_rom_addr;
    wire  [8:0]  o_ram_addr;
    wire  [7:0]  o_cpu_rdata, o_ext_wdata, i_ext_rdata, o_ram_wdata, i_ram_rdata;
    wire  [7:0]  i_rom_rdata, o_boot_addr, i_boot_rdata;
    wire         o_pready, o_pslverr, o_cpu_ack, o_ext_rw, o_address_latch_strobe;
    wire         o_ext_data_oe, o_ram_we, o_pump_voltage_enable;
    int          fail_count = 0, checked = 0, cyc = 0;
    // rows: write flag, address, write data, expected byte
    logic [32:0] rows [6] = '{{1'b1, 16'hD010, 8'h33, 8'h33},
                              {1'b0, 16'hD010, 8'h00, 8'h33},
                              {1'b0, 16'hE005, 8'h00, 8'hA0},
                              {1'b0, 16'h1000, 8'h00, 8'hFF},
                              {1'b0, 16'h0010, 8'h00, 8'hC3},
                              {1'b1, 16'h4000, 8'h77, 8'h77}};
    always #2.5 i_clk = ~i_clk;
    ocm_memory_ctrl ocm_memory_ctrl_i (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_cpu_req(i_cpu_req), .i_cpu_we(i_cpu_we),
        .i_cpu_vec(i_cpu_vec), .i_cpu_addr(i_cpu_addr), .i_cpu_wdata(i_cpu_wdata),
        .o_cpu_rdata(o_cpu_rdata), .o_cpu_ack(o_cpu_ack), .o_ext_rw(o_ext_rw),
        .o_address_latch_strobe(o_address_latch_strobe), .o_ext_addr(o_ext_addr),
        .o_ext_wdata(o_ext_wdata), .o_ext_data_oe(o_ext_data_oe), .i_ext_rdata(i_ext_rdata),
        .o_ram_we(o_ram_we), .o_ram_addr(o_ram_addr), .o_ram_wdata(o_ram_wdata), .i_ram_rdata(i_ram_rdata),
        .o_rom_addr(o_rom_addr), .i_rom_rdata(i_rom_rdata), .o_boot_addr(o_boot_addr),
        .i_boot_rdata(i_boot_rdata), .i_mode(i_mode), .i_cfg_cells(i_cfg_cells),
        .o_pump_voltage_enable(o_pump_voltage_enable));
    ocm_far_model ocm_far_model_i (.i_clk(i_clk), .i_ram_we(o_ram_we), .i_ram_addr(o_ram_addr),
        .i_ram_wdata(o_ram_wdata), .i_rom_addr(o_rom_addr), .i_boot_addr(o_boot_addr),
        .i_ext_data_oe(o_ext_data_oe), .o_ram_rdata(i_ram_rdata), .o_rom_rdata(i_rom_rdata),
        .o_boot_rdata(i_boot_rdata), .o_ext_rdata(i_ext_rdata));
    //****************************************
    // tasks
    //****************************************
    task automatic complete_run;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            complete_run;
        end
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rst_to(input logic [1:0] m, input logic [1:0] c);
        @(posedge i_clk);
        i_rst <= 1;
        i_mode <= m;
        i_cfg_cells <= c;
        repeat (16) @(posedge i_clk);
        i_rst <= 0;
        repeat (2) @(posedge i_clk);
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_psel <= 1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= {24'h0, d};
        @(posedge i_clk);
        i_penable <= 1;
        @(posedge i_clk);
        while (o_pready !== 1'b1) @(posedge i_clk);
        q = o_prdata[7:0];
        err = o_pslverr;
        i_psel <= 0;
        i_penable <= 0;
    endtask
    task automatic cpu(input logic w, input logic v, input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_cpu_req <= 1;
        i_cpu_we <= w;
        i_cpu_vec <= v;
        i_cpu_addr <= a;
        i_cpu_wdata <= d;
        @(posedge i_clk);
        i_cpu_req <= 0;
        #1;
        cmp(o_cpu_ack, 1);
    endtask
    task automatic rd(input logic v, input logic [15:0] a, input logic [7:0] e);
        cpu(0, v, a, 8'h00);
        cmp(o_cpu_rdata, e);
    endtask
    // the second write lands while the pump is on and must be dropped
    task automatic nv(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
        apb(1, a_prog, c & 8'hFE);
        cpu(1, 0, a, d);
        apb(1, a_prog, c);
        cpu(1, 0, a, ~d);
        cmp(o_pump_voltage_enable, 1);
        rd(0, a, 8'hFF);
        apb(1, a_prog, 8'h00);
    endtask
    //****************************************
    // main sequence
    //****************************************
    initial begin
        rst_to(2'b11, 2'b11);
        apb(0, a_remap, 8'h00);
        cmp(q, 8'h01);
        apb(0, a_prog, 8'h00);
        cmp(q, 8'h00);
        apb(1, a_remap, 8'hD1);
        apb(1, a_remap, 8'h01);
        apb(0, a_remap, 8'h00);
        cmp(q, 8'hD1);
        apb(0, 16'h0000, 8'h00);
        cmp(err, 1);
        foreach (rows[k]) begin
            cpu(rows[k][32], 0, rows[k][31:16], rows[k][15:8]);
            cmp(o_ext_addr, rows[k][31:16]);
            cmp(o_ext_data_oe, rows[k][32]);
            cmp(rows[k][32] ? o_ext_wdata : o_cpu_rdata, rows[k][7:0]);
        end
        apb(1, a_prog, 8'hFF);
        apb(0, a_prog, 8'h00);
        cmp(q, 8'hDC);
        apb(1, a_prog, 8'h00);
        nv(8'h07, 16'hB600, 8'h00);
        rd(0, 16'hB7FF, 8'hFF);
        nv(8'h03, 16'hB600, 8'h55);
        nv(8'h03, 16'hB610, 8'h0F);
        nv(8'h03, 16'hB600, 8'hF0);
        cpu(1, 0, 16'hB600, 8'h00);
        rd(0, 16'hB600, 8'h50);
        apb(1, a_prog, 8'h01);
        rd(0, 16'hB600, 8'h50);
        nv(8'h17, 16'hB600, 8'h00);
        rd(0, 16'hB600, 8'hFF);
        rd(0, 16'hB610, 8'h0F);
        nv(8'h0F, 16'hB615, 8'h00);
        rd(0, 16'hB610, 8'hFF);
        rst_to(2'b10, 2'b00);
        apb(1, a_remap, 8'h02);
        rd(0, 16'h203D, 8'h02);
        rd(0, 16'hD005, 8'hC3);
        rd(0, 16'hB600, 8'hC3);
        rd(1, 16'hFFFE, 8'hC3);
        cmp(o_ext_addr, 16'hBFFE);
        rst_to(2'b01, 2'b00);
        rd(0, 16'hD005, 8'hA0);
        rd(0, 16'hBF40, 8'hFF);
        rst_to(2'b00, 2'b00);
        rd(0, 16'hBF40, 8'h3C);
        rd(1, 16'hFFFE, 8'h82);
        repeat (64) @(posedge i_clk);
        apb(1, a_remap, 8'h11);
        apb(0, a_remap, 8'h00);
        cmp(q, 8'h01);
        complete_run;
    end
endmodule
`default_nettype wire
